// [logic/stx_pkg.sv]
package stx_pkg;

   // three-level select pin codes: 2'b11 is an open pin
   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} stx_lvl_e;

   localparam int CHAR_DIV = 8;
   localparam int PAB_DEPTH = 4;
   localparam int PAB_CENTER = 2;
   localparam logic [3:0] WS_LAST = 4'hf;
   localparam logic [7:0] K28_5_BYTE = 8'hbc;
   localparam logic [9:0] C07_ABCDEI_FGHJ = 10'h278;
   localparam logic [5:0] K28_6B = 6'h0f;
   localparam logic [3:0] K_Y7_4B = 4'h8;
   localparam logic [5:0] D07_6B = 6'h38;
   localparam logic [3:0] DX3_4B = 4'hc;
   localparam logic [3:0] A7_4B = 4'h7;
   localparam logic [8:0] BIST_SEED = 9'h1ff;
   localparam logic [1:0] CTL_WORD_SYNC = 2'h3;
   localparam logic [1:0] CTL_SPECIAL = 2'h1;

   function automatic stx_lvl_e stx_lvl_decode(input logic [1:0] code);
      case (code)
         2'h0: return LVL_LOW;
         2'h2: return LVL_HIGH;
         default: return LVL_MID;
      endcase
   endfunction : stx_lvl_decode

endpackage : stx_pkg

// [logic/stx_enc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface stx_enc_if;
   logic valid;
   logic is_k;
   logic is_viol;
   logic [7:0] data;
   logic [9:0] code;
   modport path (output valid, output is_k, output is_viol, output data, input code);
   modport enc (input valid, input is_k, input is_viol, input data, output code);
endinterface : stx_enc_if
`default_nettype wire

// [logic/stx_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module stx_encoder (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // character request and code
   stx_enc_if.enc e
);
   // abcdei forms for negative running disparity
   localparam logic [5:0] T6 [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   localparam logic [3:0] K4 [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};

   logic rd;
   logic next_rd;
   logic [9:0] lit;

   always_comb begin
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] c6;
      logic [3:0] d4;
      logic [9:0] w;
      logic r6;
      logic k_ok;
      x = e.data[4:0];
      y = e.data[7:5];
      c6 = T6[x];
      d4 = T4[y];
      w = stx_pkg::C07_ABCDEI_FGHJ;
      r6 = rd ^ ($countones(c6) != 3);
      k_ok = (x == 5'd28) || (y == 3'd7 && (x == 5'd23 || x == 5'd27 || x == 5'd29
         || x == 5'd30));
      lit = '0;
      next_rd = rd;
      if (e.is_viol || e.is_k) begin
         if (!e.is_viol && k_ok) begin
            w = (x == 5'd28) ? {stx_pkg::K28_6B, K4[y]} : {c6, stx_pkg::K_Y7_4B};
         end
         lit = rd ? ~w : w;
         next_rd = rd ^ ($countones(w) != 5);
      end else begin
         if (rd && ($countones(c6) != 3 || c6 == stx_pkg::D07_6B)) begin
            c6 = ~c6;
         end
         if (y == 3'd7 && ((!r6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
               || (r6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)))) begin
            d4 = stx_pkg::A7_4B;
         end
         next_rd = r6 ^ ($countones(d4) != 2);
         if (r6 && ($countones(d4) != 2 || d4 == stx_pkg::DX3_4B)) begin
            d4 = ~d4;
         end
         lit = {c6, d4};
      end
   end

   // bit a leaves the shifter first, so it lands in bit 0
   assign e.code = {<<{lit}};

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd <= 1'b0;
      end else if (e.valid) begin
         rd <= next_rd; // [RULE24]
      end
   end

   a_rd_tracks_code: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE24]
      e.valid && ($countones(e.code) != 5) |=> rd != $past(rd))
      else $error("running disparity did not flip after unbalanced code");
   a_k285_neg_form: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE22]
      e.valid && e.is_k && !e.is_viol && e.data == stx_pkg::K28_5_BYTE && !rd
      |-> e.code == 10'h17c)
      else $error("wrong K28.5 negative disparity form");

endmodule : stx_encoder
`default_nettype wire

// [logic/stx_input_path.sv]
// Operation
// RULE1 - capture eight data, two control bits per clock
// RULE2 - bypass: control bits top of ten-bit character
// RULE3 - upper mode not LOW enables encoder
// RULE4 - lower mode not HIGH captures special select
// RULE5 - synchronous reference clocking skips phase buffer
// RULE6 - other clocking routes through phase buffer
// RULE7 - two low samples initialize, release sets phase
// RULE8 - buffer reset synchronized before use
// RULE9 - buffer tolerates half character drift
// RULE10 - buffer error holds error flag until reset
// RULE11 - buffer error sends violation character continuously
// RULE12 - atomic word sync recenters buffer, clears error
// RULE13 - host may repeat word sync after recenter
// RULE14 - odd parity check, off when control LOW
// RULE15 - MID encoded: data plus parity bit checked
// RULE16 - HIGH, or MID bypass: all bits checked
// RULE17 - encoded parity error: C0.7 at running disparity
// RULE18 - bypass parity error: positive C0.7 always
// RULE19 - positive error pattern is 1001111000
// RULE20 - parity errors raise the error flag
// RULE21 - self-test sequence of 511 characters
// RULE22 - K28.5 alone or sixteen-character word sync
// RULE23 - two three-level selects give nine modes
// RULE24 - encoded modes use disparity tracking 8B/10B
// RULE25 - three-level pins decode, open reads MID
`timescale 1ns/1ps
`default_nettype none
module stx_input_path #(
   parameter int CHAR_DIV = stx_pkg::CHAR_DIV,
   parameter int PAB_DEPTH = stx_pkg::PAB_DEPTH
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // host character pins
   input wire logic [7:0] tx_data_i,
   input wire logic [1:0] tx_control_bits_i,
   input wire logic special_code_select_i,
   input wire logic tx_parity_bit_i,
   input wire logic input_word_clock_i,
   input wire logic phase_buffer_reset_n_i,
   // configuration pins, three-level codes except the two-level rate select and self-test enable
   input wire logic [3:0] tx_mode_select_i,
   input wire logic [1:0] parity_check_control_i,
   input wire logic [1:0] input_clock_select_i,
   input wire logic input_rate_select_i,
   input wire logic bist_enable_i,
   // to the shifter
   output logic [9:0] tx_char_o,
   output logic tx_char_valid_o,
   output logic tx_error_flag_o
);
   localparam int AW = $clog2(PAB_DEPTH);
   localparam int DW = $clog2(CHAR_DIV);

   if (CHAR_DIV < 2) begin : g_div_chk
      $error("CHAR_DIV must be at least 2");
   end
   if (PAB_DEPTH < 2 * stx_pkg::PAB_CENTER || (1 << AW) != PAB_DEPTH) begin : g_depth_chk
      $error("PAB_DEPTH must be a power of two, at least 4");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // synchronizers

   logic [11:0] hb_s1, hb_s2;
   logic [9:0] cfg_s1, cfg_s2;
   logic wclk_s1, wclk_s2, wclk_s3;
   logic prst_s1, prst_s2;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hb_s1 <= '0;
         hb_s2 <= '0;
         cfg_s1 <= '0;
         cfg_s2 <= '0;
         wclk_s1 <= 1'b0;
         wclk_s2 <= 1'b0;
         wclk_s3 <= 1'b0;
         prst_s1 <= 1'b1;
         prst_s2 <= 1'b1;
      end else begin
         hb_s1 <= {tx_parity_bit_i, special_code_select_i, tx_control_bits_i, tx_data_i};
         hb_s2 <= hb_s1;
         cfg_s1 <= {tx_mode_select_i, parity_check_control_i, input_clock_select_i,
            input_rate_select_i, bist_enable_i};
         cfg_s2 <= cfg_s1;
         wclk_s1 <= input_word_clock_i;
         wclk_s2 <= wclk_s1;
         wclk_s3 <= wclk_s2;
         prst_s1 <= phase_buffer_reset_n_i; // [RULE8]
         prst_s2 <= prst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode

   stx_pkg::stx_lvl_e mode_hi, mode_lo, par_lvl, cksel;
   logic rate, bist, enc_on, sc_cap, atomic, ws_by_sc, buf_en;

   always_comb begin
      mode_hi = stx_pkg::stx_lvl_decode(cfg_s2[9:8]); // [RULE25] [RULE23]
      mode_lo = stx_pkg::stx_lvl_decode(cfg_s2[7:6]);
      par_lvl = stx_pkg::stx_lvl_decode(cfg_s2[5:4]);
      cksel = stx_pkg::stx_lvl_decode(cfg_s2[3:2]);
      rate = cfg_s2[1];
      bist = cfg_s2[0];
      enc_on = mode_hi != stx_pkg::LVL_LOW; // [RULE3]
      sc_cap = mode_lo != stx_pkg::LVL_HIGH; // [RULE4]
      atomic = mode_hi == stx_pkg::LVL_MID;
      ws_by_sc = enc_on && mode_lo == stx_pkg::LVL_MID;
      buf_en = !(cksel == stx_pkg::LVL_LOW && !rate); // [RULE5] [RULE6]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // character clock enable

   logic [DW-1:0] div_cnt;
   logic char_stb;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= '0;
         char_stb <= 1'b0;
      end else begin
         char_stb <= div_cnt == DW'(CHAR_DIV - 1);
         div_cnt <= (div_cnt == DW'(CHAR_DIV - 1)) ? '0 : div_cnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // phase-align buffer reset: two low samples in a row

   logic prst_low_seen, buf_hold, pab_release;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prst_low_seen <= 1'b0;
         buf_hold <= 1'b0;
      end else begin
         prst_low_seen <= !prst_s2;
         if (prst_s2) begin
            buf_hold <= 1'b0;
         end else if (prst_low_seen) begin
            buf_hold <= 1'b1; // [RULE7]
         end
      end
   end

   assign pab_release = buf_hold && prst_s2;

   ////////////////////////////////////////////////////////////////////////////////
   // phase-align buffer

   logic [11:0] mem [PAB_DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, count;
   logic buf_ready, prime, pab_err, wr_stb, recenter;
   logic [11:0] cur;
   logic cur_ok;

   assign count = wr_ptr - rd_ptr;
   assign wr_stb = buf_en && (cksel == stx_pkg::LVL_LOW ? char_stb : wclk_s2 && !wclk_s3);
   assign cur = buf_en ? mem[rd_ptr[AW-1:0]] : hb_s2; // [RULE1]
   assign cur_ok = !buf_en || (buf_ready && !prime && count != '0);

   // margin of PAB_CENTER words either way covers half a character of drift
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         buf_ready <= 1'b0;
         prime <= 1'b0;
         pab_err <= 1'b0;
      end else if (buf_hold && !prst_s2) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         buf_ready <= 1'b0;
         prime <= 1'b0;
         pab_err <= 1'b0;
      end else begin
         if (pab_release || recenter) begin
            buf_ready <= 1'b1; // [RULE7] [RULE12]
            prime <= 1'b1;
            pab_err <= 1'b0;
            rd_ptr <= wr_ptr;
         end else if (char_stb && buf_en && buf_ready) begin
            if (prime) begin
               prime <= count < (AW + 1)'(stx_pkg::PAB_CENTER); // [RULE9]
            end else if (count == '0) begin
               pab_err <= 1'b1; // [RULE10]
            end else begin
               rd_ptr <= rd_ptr + 1'b1;
            end
         end
         if (wr_stb && buf_ready) begin
            if (count == (AW + 1)'(PAB_DEPTH)) begin
               pab_err <= 1'b1; // [RULE10]
            end else begin
               wr_ptr <= wr_ptr + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (wr_stb && buf_ready && count != (AW + 1)'(PAB_DEPTH)) begin
         mem[wr_ptr[AW-1:0]] <= hb_s2; // [RULE1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // parity, word sync, self-test

   logic [7:0] cd;
   logic [1:0] cc;
   logic csc, cp, par_bad, ws_req, ws_start, ws_cont, ws_active, show_err;
   logic [3:0] ws_cnt;
   logic [8:0] lfsr;

   always_comb begin
      cd = cur[7:0];
      cc = cur[9:8];
      csc = cur[10] && sc_cap; // [RULE4]
      cp = cur[11];
      par_bad = cur_ok && !ws_active && !bist && ( // [RULE14]
         ((par_lvl == stx_pkg::LVL_HIGH || (par_lvl == stx_pkg::LVL_MID && !enc_on))
            && !(^{cd, cc, cp})) // [RULE16]
         || (par_lvl == stx_pkg::LVL_MID && enc_on && !(^{cd, cp}))); // [RULE15]
      ws_req = enc_on && cur_ok && (cc == stx_pkg::CTL_WORD_SYNC || (ws_by_sc && csc));
      ws_cont = ws_active && (atomic || ws_req);
      ws_start = char_stb && !ws_active && ws_req && !par_bad && !bist;
      recenter = ws_start && atomic && pab_err; // [RULE12]
      show_err = pab_err && !recenter;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ws_active <= 1'b0;
         ws_cnt <= '0;
      end else if (char_stb) begin
         if (ws_cont) begin
            ws_cnt <= ws_cnt + 1'b1;
            ws_active <= ws_cnt != stx_pkg::WS_LAST; // [RULE22]
         end else if (ws_start) begin
            ws_active <= 1'b1;
            ws_cnt <= 4'h1;
         end else begin
            ws_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lfsr <= stx_pkg::BIST_SEED;
      end else if (!bist) begin
         lfsr <= stx_pkg::BIST_SEED;
      end else if (char_stb) begin
         lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]}; // [RULE21]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // character selection

   stx_enc_if enc_bus ();
   logic use_enc;
   logic [9:0] raw_val;

   always_comb begin
      use_enc = 1'b1;
      raw_val = cur[9:0];
      enc_bus.is_k = 1'b1;
      enc_bus.is_viol = 1'b0;
      enc_bus.data = stx_pkg::K28_5_BYTE;
      if (show_err || (cur_ok && par_bad && !bist && !ws_cont)) begin
         use_enc = enc_on; // [RULE11] [RULE17]
         enc_bus.is_viol = 1'b1;
         raw_val = {<<{stx_pkg::C07_ABCDEI_FGHJ}}; // [RULE18] [RULE19]
      end else if (bist) begin
         enc_bus.is_k = 1'b0; // [RULE21]
         enc_bus.data = lfsr[7:0];
      end else if (ws_cont || ws_start || !cur_ok) begin
         enc_bus.data = stx_pkg::K28_5_BYTE; // [RULE22]
      end else if (!enc_on) begin
         use_enc = 1'b0; // [RULE2]
      end else if (!cc[0]) begin
         enc_bus.is_k = 1'b0; // [RULE3]
         enc_bus.data = cd;
      end else if (cc == stx_pkg::CTL_SPECIAL && csc && !ws_by_sc) begin
         enc_bus.data = cd; // [RULE4]
      end
      enc_bus.valid = char_stb && use_enc;
   end

   stx_encoder u_enc (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .e(enc_bus)
   );

   logic par_flag;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_char_o <= '0;
         tx_char_valid_o <= 1'b0;
         par_flag <= 1'b0;
         tx_error_flag_o <= 1'b0;
      end else begin
         tx_char_valid_o <= char_stb;
         if (char_stb) begin
            tx_char_o <= use_enc ? enc_bus.code : raw_val;
            par_flag <= par_bad && !show_err && !ws_cont; // [RULE20]
         end
         tx_error_flag_o <= pab_err || par_flag; // [RULE10] [RULE20]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   a_err_flag_hold: assert property (pab_err |=> tx_error_flag_o) // [RULE10]
      else $error("buffer error not shown on error flag");
   a_pab_bypass_viol: assert property (char_stb && show_err && !enc_on // [RULE11]
      |=> tx_char_o == 10'h079)
      else $error("buffer error did not send violation character");
   a_bypass_passes: assert property (char_stb && !enc_on && !show_err && !bist // [RULE2]
      && cur_ok && !par_bad |=> tx_char_o == $past(cur[9:0]))
      else $error("bypass character altered");
   a_par_bypass_sub: assert property (char_stb && !enc_on && !bist && par_bad // [RULE18]
      |=> tx_char_o == 10'h079)
      else $error("bypass parity error pattern wrong");
   a_par_flag_set: assert property (char_stb && par_bad && !show_err && !ws_cont // [RULE20]
      |=> ##1 tx_error_flag_o)
      else $error("parity error not flagged");
   a_buf_init_hold: assert property (!prst_s2 ##1 !prst_s2 |=> buf_hold) // [RULE7]
      else $error("buffer reset not taken after two low samples");
   a_ws_recenter: assert property (recenter |=> !pab_err && prime) // [RULE12]
      else $error("word sync did not recenter buffer");
   a_sync_no_buffer: assert property (!buf_en |-> cur_ok && !wr_stb) // [RULE5]
      else $error("buffer used in synchronous clocking");
   a_ws_ends: assert property (char_stb && ws_cont && ws_cnt == 4'hf // [RULE22]
      |=> !ws_active)
      else $error("word sync ran past sixteen characters");

endmodule : stx_input_path
`default_nettype wire

// [testbench/stx_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module stx_host_model (
   // control from the bench
   input wire logic run_i,
   input wire logic [10:0] char_i,
   // host pins
   output logic input_word_clock_o,
   output logic [10:0] pins_o
);
   logic [10:0] held;

   ////////////////////////////////////////////////////////////////////////////////
   // input clock stands still low between bursts, phase unrelated to ref clock
   initial begin
      input_word_clock_o = 1'b0;
      held = 11'h000;
      forever begin
         wait (run_i);
         held = char_i;
         #37;
         while (run_i) begin
            #400 input_word_clock_o = 1'b1;
            #400 input_word_clock_o = 1'b0;
            held = char_i; // one character per input clock, set clear of the rising edge
         end
      end
   end

   // outside bursts the bench places characters straight on the pins
   assign pins_o = run_i ? held : char_i;
endmodule : stx_host_model
`default_nettype wire

// [testbench/serial_tx_input_path_test.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_tx_input_path_test;
   // error character, bit a first, mapped to {j,h,g,f,i,e,d,c,b,a}
   localparam logic [9:0] C07P = 10'h079;
   logic ref_clk_i;
   logic arst_n_i;
   logic run;
   logic [10:0] char_in;
   logic [10:0] pins;
   logic word_clk;
   logic pbr_n;
   logic [3:0] mode;
   logic [1:0] pctl;
   logic [1:0] csel;
   logic scs;
   logic rate;
   logic bist;
   logic [9:0] tx_char_o;
   logic tx_char_valid_o;
   logic tx_error_flag_o;
   logic [9:0] ch;
   logic er;
   int n_fail;
   int samples_checked;
   int n;

   ////////////////////////////////////////////////////////////////////////////////
   stx_host_model host (
      .run_i(run),
      .char_i(char_in),
      .input_word_clock_o(word_clk),
      .pins_o(pins)
   );

   stx_input_path #(.CHAR_DIV(8), .PAB_DEPTH(4)) uut (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .tx_data_i(pins[7:0]),
      .tx_control_bits_i(pins[9:8]),
      .special_code_select_i(scs),
      .tx_parity_bit_i(pins[10]),
      .input_word_clock_i(word_clk),
      .phase_buffer_reset_n_i(pbr_n),
      .tx_mode_select_i(mode),
      .parity_check_control_i(pctl),
      .input_clock_select_i(csel),
      .input_rate_select_i(rate),
      .bist_enable_i(bist),
      .tx_char_o(tx_char_o),
      .tx_char_valid_o(tx_char_valid_o),
      .tx_error_flag_o(tx_error_flag_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // present one character, wait for its strobe, then read the error flag
   task automatic send(input logic [10:0] c);
      int k;
      @(posedge ref_clk_i);
      char_in <= c;
      repeat (3) @(posedge ref_clk_i);
      k = 0;
      do begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end while (tx_char_valid_o !== 1'b1 && k < 20);
      check("valid", {9'h0, tx_char_valid_o}, 10'h001);
      ch = tx_char_o;
      @(posedge ref_clk_i);
      #1;
      er = tx_error_flag_o;
   endtask : send

   task automatic pulse_buffer_reset();
      @(posedge ref_clk_i);
      pbr_n <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      pbr_n <= 1'b1;
   endtask : pulse_buffer_reset

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #3000000;
      n_fail++;
      finish_test();
   end

   initial begin
      logic [9:0] vals [4];
      vals = '{10'h3ff, 10'h155, 10'h2aa, 10'h000};
      n_fail = 0;
      samples_checked = 0;
      arst_n_i = 1'b0;
      run = 1'b0;
      char_in = 11'h000;
      pbr_n = 1'b1;
      mode = 4'h0;
      pctl = 2'h1;
      csel = 2'h0;
      scs = 1'b0;
      rate = 1'b0;
      bist = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      // synchronous bypass, good odd parity over all ten bits
      foreach (vals[i]) begin
         send({~^vals[i], vals[i]});
         check("bypass char", ch, vals[i]);
         check("bypass flag", {9'h0, er}, 10'h000);
      end
      // a control bit spoils parity under MID in bypass
      send({1'b1, 10'h100});
      check("bypass c07", ch, C07P);
      check("bypass perr", {9'h0, er}, 10'h001);
      pctl <= 2'h0;
      send({1'b1, 10'h100});
      check("unchecked char", ch, 10'h100);
      check("unchecked flag", {9'h0, er}, 10'h000);
      // encoded mode, upper MID lower HIGH
      mode <= 4'h6;
      pctl <= 2'h3; // open pin reads MID
      send({1'b1, 10'h100});
      check("mid enc flag", {9'h0, er}, 10'h000);
      check("mid enc fill", {9'h0, (ch === 10'h17c || ch === 10'h283)}, 10'h001);
      pctl <= 2'h2;
      send({1'b1, 10'h100});
      check("high enc flag", {9'h0, er}, 10'h001);
      check("enc c07", {9'h0, (ch === C07P || ch === ~C07P)}, 10'h001);
      // special select taken only while the lower mode is not HIGH
      mode <= 4'h4;
      pctl <= 2'h1;
      scs <= 1'b1;
      send({1'b0, 2'b01, 8'h1c});
      check("special k28.0", {9'h0, (ch === 10'h0bc || ch === 10'h343)}, 10'h001);
      mode <= 4'h6;
      send({1'b0, 2'b01, 8'h1c});
      check("special ignored", {9'h0, (ch === 10'h17c || ch === 10'h283)}, 10'h001);
      // self-test opens with the seed byte, a D31.7 character
      scs <= 1'b0;
      bist <= 1'b1;
      send({1'b0, 2'b01, 8'h1c});
      check("bist first", {9'h0, (ch === 10'h235 || ch === 10'h1ca)}, 10'h001);
      bist <= 1'b0;
      // buffered input clocking through the phase-align buffer
      mode <= 4'h0;
      pctl <= 2'h1;
      csel <= 2'h1;
      char_in <= {~^10'h155, 10'h155};
      run <= 1'b1;
      pulse_buffer_reset();
      n = 0;
      while (!(tx_char_valid_o === 1'b1 && tx_char_o === 10'h155) && n < 600) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("buffered data", {9'h0, (n < 600)}, 10'h001);
      check("buffered flag", {9'h0, tx_error_flag_o}, 10'h000);
      // input clock stops: buffer runs dry
      run <= 1'b0;
      n = 0;
      while (tx_error_flag_o !== 1'b1 && n < 400) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("underflow flag", {9'h0, (n < 400)}, 10'h001);
      repeat (3) begin
         send({~^10'h155, 10'h155});
         check("violation char", ch, C07P);
         check("flag held", {9'h0, er}, 10'h001);
      end
      // restart the input clock and reset the buffer
      run <= 1'b1;
      pulse_buffer_reset();
      repeat (30) @(posedge ref_clk_i);
      #1;
      check("flag cleared", {9'h0, tx_error_flag_o}, 10'h000);
      // atomic word sync recenters a buffer that ran dry
      run <= 1'b0;
      n = 0;
      while (tx_error_flag_o !== 1'b1 && n < 400) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("second underflow", {9'h0, (n < 400)}, 10'h001);
      mode <= 4'h6;
      char_in <= {1'b1, 2'b11, 8'h00}; // word sync kept up for a second sequence
      run <= 1'b1;
      n = 0;
      while (tx_error_flag_o !== 1'b0 && n < 600) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("recenter clears", {9'h0, (n < 600)}, 10'h001);
      send({1'b1, 2'b11, 8'h00});
      check("word sync char", {9'h0, (ch === 10'h17c || ch === 10'h283)}, 10'h001);
      check("word sync flag", {9'h0, er}, 10'h000);
      // reference clocking with rate select HIGH still runs through the buffer
      run <= 1'b0;
      mode <= 4'h0;
      csel <= 2'h0;
      rate <= 1'b1;
      char_in <= {~^10'h2aa, 10'h2aa};
      pulse_buffer_reset();
      n = 0;
      while (!(tx_char_valid_o === 1'b1 && tx_char_o === 10'h2aa) && n < 600) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check("rate buffered", {9'h0, (n < 600)}, 10'h001);
      check("rate flag", {9'h0, tx_error_flag_o}, 10'h000);
      finish_test();
   end
endmodule : serial_tx_input_path_test
`default_nettype wire
